// *** rtl/wdg_pkg.sv ***
// Shared constants for the watchdog timer block
package wdg_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned OSC_DIV_DEFAULT = 16;
  localparam int unsigned WDG_PRESCALE = 16384;
  localparam int unsigned PRESCALE_W = 14;
  localparam logic [15:0] CTRL_ADDR = 16'h002a;
  localparam logic [7:0] CTRL_RESET = 8'h7f;
  localparam int unsigned ACT_BIT = 7;
  localparam int unsigned TOP_BIT = 6;
  localparam int unsigned CNT_W = 7;
  localparam logic [6:0] CNT_TRIP_FROM = 7'h40;
  localparam int unsigned RST_PULSE_NS = 30_000;
  localparam int unsigned RST_PULSE_CYCLES = (RST_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned WAKE_SHORT_CYCLES = 256;
  localparam int unsigned WAKE_LONG_CYCLES = 4096;
  localparam int unsigned WAKE_W = 13;
  // Timebase periods in oscillator ticks for 2, 4, 10 and 25 ms at 8 MHz
  localparam int unsigned TB_W = 18;
  localparam logic [17:0] TB_PERIOD_2MS = 18'h03e80;
  localparam logic [17:0] TB_PERIOD_4MS = 18'h07d00;
  localparam logic [17:0] TB_PERIOD_10MS = 18'h13880;
  localparam logic [17:0] TB_PERIOD_25MS = 18'h30d40;
endpackage : wdg_pkg

// *** rtl/wdg_prescaler.sv ***
// Oscillator divider and prescaler shared by watchdog and timebase
`timescale 1ns/1ps
module wdg_prescaler import wdg_pkg::*; #(
  parameter int unsigned OSC_DIV = OSC_DIV_DEFAULT
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] timebase_select_i,
  output logic wdg_tick_o,
  output logic timebase_tick_o
);
  initial begin
    if (OSC_DIV < 1 || OSC_DIV > 256) $error("OSC_DIV out of range");
  end

  logic [7:0] div_q, div_d;
  logic [PRESCALE_W-1:0] pre_q, pre_d;
  logic [TB_W-1:0] tb_q, tb_d;
  logic [TB_W-1:0] tb_period;
  logic osc_tick;

  always_comb begin
    case (timebase_select_i)
      2'h0: tb_period = TB_PERIOD_2MS;
      2'h1: tb_period = TB_PERIOD_4MS;
      2'h2: tb_period = TB_PERIOD_10MS;
      default: tb_period = TB_PERIOD_25MS;
    endcase
  end

  // Prescaler phase is never realigned by a counter write
  always_comb begin
    osc_tick = (div_q == 8'(OSC_DIV - 1));
    div_d = osc_tick ? 8'h00 : div_q + 8'h01;
    pre_d = osc_tick ? pre_q + 14'h0001 : pre_q;
    tb_d = tb_q;
    if (osc_tick) begin
      tb_d = (tb_q >= tb_period - 18'h00001) ? 18'h00000 : tb_q + 18'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q <= 8'h00;
      pre_q <= '0;
      tb_q <= '0;
      wdg_tick_o <= 1'b0;
      timebase_tick_o <= 1'b0;
    end else begin
      div_q <= div_d;
      pre_q <= pre_d;
      tb_q <= tb_d;
      wdg_tick_o <= osc_tick && (pre_q == PRESCALE_W'(WDG_PRESCALE - 1));
      timebase_tick_o <= osc_tick && (tb_d == 18'h00000);
    end
  end
endmodule : wdg_prescaler

// *** rtl/wdg_reset_pulse.sv ***
// Stretches a reset request into a fixed low pulse on the reset pin
`timescale 1ns/1ps
module wdg_reset_pulse import wdg_pkg::*; #(
  parameter int unsigned PULSE_CYCLES = RST_PULSE_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic trigger_i,
  output logic rst_pin_n_o,
  output logic busy_o
);
  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 4095) $error("PULSE_CYCLES out of range");
  end

  logic [11:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (cnt_q != 12'h000) begin
      cnt_d = cnt_q - 12'h001;
    end else if (trigger_i) begin
      cnt_d = 12'(PULSE_CYCLES);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign rst_pin_n_o = (cnt_q == 12'h000);
  assign busy_o = (cnt_q != 12'h000);
endmodule : wdg_reset_pulse

// *** rtl/windowless_watchdog_timer.sv ***
// Watchdog timer: control register, downcounter, halt handling, reset generation
//
// Overview of operation
// - Counter decrements once per 16384 oscillator ticks.
// - Low six counter bits set timeout in 64 steps.
// - Active and counter 40h to 3Fh on a prescaler tick starts a reset pulse; the halt-entry decrement does not.
// - Counter runs outside halt, active halt and wake delay states, active or not; no reset while inactive.
// - Counter writes do not realign the prescaler phase.
// - Watchdog disabled after reset unless hardware option set; software cannot disable it.
// - Write with activation set and top bit clear forces reset.
// - Halt while active with halt reset option and oscillator interrupt disabled causes reset.
// - Hardware watchdog option input fixed outside the register.
// - Prescaler shared with selectable 2/4/10/25 ms timebase.
// - Register resets to 7Fh; activation cleared only by reset.
// - Hardware option keeps watchdog active, ignores activation bit.
// - Active halt freezes counter; resumes at once on interrupt.
`timescale 1ns/1ps
module windowless_watchdog_timer import wdg_pkg::*; #(
  parameter int unsigned OSC_DIV = OSC_DIV_DEFAULT,
  parameter int unsigned PULSE_CYCLES = RST_PULSE_CYCLES,
  parameter int unsigned WAKE_SHORT = WAKE_SHORT_CYCLES,
  parameter int unsigned WAKE_LONG = WAKE_LONG_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  input wire logic hw_watchdog_opt_i,
  input wire logic halt_reset_option_i,
  input wire logic oscillator_irq_enable_i,
  input wire logic [1:0] timebase_select_i,
  input wire logic halt_exec_i,
  input wire logic ext_irq_i,
  input wire logic osc_irq_i,
  input wire logic wake_long_i,
  output logic rst_pin_n_o,
  output logic halt_enter_o,
  output logic active_halt_enter_o,
  output logic watchdog_active_o,
  output logic timebase_tick_o
);
  initial begin
    if (WAKE_SHORT < 1 || WAKE_LONG < 1 || WAKE_LONG > 8191 || WAKE_SHORT > 8191)
      $error("Wake delay out of range");
  end

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_HALT = 4'b0010,
    ST_AHALT = 4'b0100,
    ST_WAKE = 4'b1000
  } mode_t;

  mode_t mode_q, mode_d;
  logic act_q, act_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [WAKE_W-1:0] wake_q, wake_d;
  logic [7:0] rdata_q, rdata_d;
  logic wdg_tick;
  logic pulse_busy;
  logic active;
  logic ctrl_wr;
  logic trip;
  logic halt_rst;

  wdg_prescaler #(.OSC_DIV(OSC_DIV)) u_prescaler (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .timebase_select_i(timebase_select_i),
    .wdg_tick_o(wdg_tick),
    .timebase_tick_o(timebase_tick_o)
  );

  assign active = act_q | hw_watchdog_opt_i;
  assign ctrl_wr = we_i && (addr_i == CTRL_ADDR);
  assign halt_rst = halt_exec_i && (mode_q == ST_RUN) && active
    && halt_reset_option_i && !oscillator_irq_enable_i;

  always_comb begin
    act_d = act_q;
    cnt_d = cnt_q;
    mode_d = mode_q;
    wake_d = wake_q;
    trip = 1'b0;
    // Free-running decrement, frozen in halt, active halt and wake delay states
    if (wdg_tick && (mode_q == ST_RUN)) begin
      cnt_d = cnt_q - 7'h01;
      if (active && (cnt_q == CNT_TRIP_FROM)) begin
        trip = 1'b1;
      end
    end
    // A software write takes priority over the decrement in the same cycle
    if (ctrl_wr) begin
      cnt_d = wdata_i[CNT_W-1:0];
      if (wdata_i[ACT_BIT]) begin
        act_d = 1'b1;
      end
      if ((wdata_i[ACT_BIT] || active) && !wdata_i[TOP_BIT]) begin
        trip = 1'b1;
      end
    end
    case (mode_q)
      ST_RUN: begin
        if (halt_exec_i && !halt_rst) begin
          if (oscillator_irq_enable_i) begin
            mode_d = ST_AHALT;
          end else begin
            mode_d = ST_HALT;
            if (!ctrl_wr) begin
              cnt_d = cnt_q - 7'h01;
            end
          end
        end
      end
      ST_HALT: begin
        if (ext_irq_i) begin
          mode_d = ST_WAKE;
          wake_d = wake_long_i ? WAKE_W'(WAKE_LONG - 1) : WAKE_W'(WAKE_SHORT - 1);
        end
      end
      ST_AHALT: begin
        if (ext_irq_i || osc_irq_i) begin
          mode_d = ST_RUN;
        end
      end
      ST_WAKE: begin
        if (wake_q == '0) begin
          mode_d = ST_RUN;
        end else begin
          wake_d = wake_q - WAKE_W'(1);
        end
      end
      default: begin
        mode_d = ST_RUN;
      end
    endcase
    if (halt_rst) begin
      trip = 1'b1;
    end
    rdata_d = (re_i && (addr_i == CTRL_ADDR)) ? {act_q, cnt_q} : 8'h00;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      act_q <= CTRL_RESET[ACT_BIT];
      cnt_q <= CTRL_RESET[CNT_W-1:0];
      mode_q <= ST_RUN;
      wake_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      act_q <= act_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      wake_q <= wake_d;
      rdata_q <= rdata_d;
    end
  end

  // A system reset on srst_i clears the pulse counter and ends the pulse early
  wdg_reset_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .trigger_i(trip),
    .rst_pin_n_o(rst_pin_n_o),
    .busy_o(pulse_busy)
  );

  assign rdata_o = rdata_q;
  assign halt_enter_o = (mode_q == ST_HALT);
  assign active_halt_enter_o = (mode_q == ST_AHALT);
  assign watchdog_active_o = active && !pulse_busy;
endmodule : windowless_watchdog_timer

// *** verif/wdg_checker_asserts.sv ***
// Concurrent checks on the watchdog timer ports
`timescale 1ns/1ps
module wdg_checker import wdg_pkg::*; #(
  parameter int unsigned PULSE_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic halt_reset_option_i,
  input wire logic oscillator_irq_enable_i,
  input wire logic hw_watchdog_opt_i,
  input wire logic halt_exec_i,
  input wire logic ext_irq_i,
  input wire logic osc_irq_i,
  input wire logic rst_pin_n_o,
  input wire logic halt_enter_o,
  input wire logic active_halt_enter_o,
  input wire logic watchdog_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [15:0] low_cnt_q;
  // Counts the low cycles of the current pulse
  always_ff @(posedge clk_i) begin
    if (srst_i || rst_pin_n_o) low_cnt_q <= 16'h0000;
    else low_cnt_q <= low_cnt_q + 16'h0001;
  end
  sequence s_trip_write;
    we_i && addr_i == CTRL_ADDR && wdata_i[7] && !wdata_i[6] && rst_pin_n_o;
  endsequence
  sequence s_halt_req;
    halt_exec_i && oscillator_irq_enable_i && !active_halt_enter_o && !halt_enter_o;
  endsequence
  property p_sw_reset; s_trip_write |=> !rst_pin_n_o; endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software trip gave no pulse");
  property p_pulse_len;
    !$past(srst_i) && $rose(rst_pin_n_o) |-> low_cnt_q == 16'(PULSE_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
  property p_inactive; rst_pin_n_o && !watchdog_active_o && !we_i |=> rst_pin_n_o; endproperty
  a_inactive: assert property (p_inactive) else $error("reset while inactive");
  property p_sticky; watchdog_active_o && rst_pin_n_o |=> watchdog_active_o || !rst_pin_n_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("watchdog disabled without reset");
  property p_hw_opt; hw_watchdog_opt_i && rst_pin_n_o |-> watchdog_active_o; endproperty
  a_hw_opt: assert property (p_hw_opt) else $error("hardware option not active");
  property p_halt_rst;
    halt_exec_i && watchdog_active_o && halt_reset_option_i && !oscillator_irq_enable_i
      && rst_pin_n_o |=> !rst_pin_n_o;
  endproperty
  a_halt_rst: assert property (p_halt_rst) else $error("halt gave no reset");
  property p_act_halt; s_halt_req |=> active_halt_enter_o ##0 rst_pin_n_o; endproperty
  a_act_halt: assert property (p_act_halt) else $error("active halt not entered");
  property p_act_wake; active_halt_enter_o && (ext_irq_i || osc_irq_i) |-> ##[1:2] !active_halt_enter_o;
  endproperty
  a_act_wake: assert property (p_act_wake) else $error("active halt did not wake");
  sequence s_plain_halt_req;
    halt_exec_i && !oscillator_irq_enable_i && !halt_reset_option_i && !active_halt_enter_o
      && !halt_enter_o && rst_pin_n_o;
  endsequence
  property p_plain_halt; s_plain_halt_req |=> halt_enter_o; endproperty
  a_plain_halt: assert property (p_plain_halt) else $error("plain halt not entered");
  property p_halt_stay; halt_enter_o && !ext_irq_i |=> halt_enter_o; endproperty
  a_halt_stay: assert property (p_halt_stay) else $error("plain halt left early");
  property p_halt_wake; halt_enter_o && ext_irq_i |=> !halt_enter_o; endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("plain halt did not wake");
endmodule : wdg_checker

bind windowless_watchdog_timer wdg_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);

// *** verif/windowless_watchdog_timer_tb.sv ***
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module windowless_watchdog_timer_tb import wdg_pkg::*;;
  logic clk_i = 0, srst_i = 1, we_i = 0, re_i = 0, hw_i = 0, hro_i = 0, oie_i = 0;
  logic halt_i = 0, ext_i = 0, osc_i = 0, wl_i = 0;
  logic [1:0] tbs_i = 2'h0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic rst_n, halt_o, ahalt_o, act_o, tb_tick;
  int checked = 0, miscompares = 0;
  int n, lows, t1, t2;
  windowless_watchdog_timer #(.OSC_DIV(1), .PULSE_CYCLES(4), .WAKE_SHORT(2), .WAKE_LONG(4)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .hw_watchdog_opt_i(hw_i), .halt_reset_option_i(hro_i),
    .oscillator_irq_enable_i(oie_i), .timebase_select_i(tbs_i), .halt_exec_i(halt_i),
    .ext_irq_i(ext_i), .osc_irq_i(osc_i), .wake_long_i(wl_i), .rst_pin_n_o(rst_n),
    .halt_enter_o(halt_o), .active_halt_enter_o(ahalt_o), .watchdog_active_o(act_o),
    .timebase_tick_o(tb_tick));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clk_i);
    re_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    `CHK("rdata", e & m, rdata_o & m)
  endtask : rd
  task automatic pulse_halt;
    @(posedge clk_i);
    halt_i <= 1'b1;
    @(posedge clk_i);
    halt_i <= 1'b0;
    #1;
  endtask : pulse_halt
  task automatic do_reset;
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : do_reset
  initial begin
    do_reset();
    rd(CTRL_ADDR, 8'h7f);
    rd(16'h0000, 8'h00);
    $display("test reset values done");
    wr(CTRL_ADDR, 8'hc5);
    rd(CTRL_ADDR, 8'hc5);
    wr(CTRL_ADDR, 8'h45);
    rd(CTRL_ADDR, 8'hc5);
    $display("test activation done");
    // Counter 41h needs two ticks; prescaler phase is unknown, so allow both
    wr(CTRL_ADDR, 8'hc1);
    for (n = 0; n < 33000 && rst_n === 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    `CHK("timeout pulse", 1'b0, rst_n)
    `CHK("timeout window", 1'b1, n >= WDG_PRESCALE && n <= 2 * WDG_PRESCALE + 4)
    if (rst_n !== 1'b0) end_sim();
    do_reset();
    `CHK("active after reset", 1'b0, act_o)
    $display("test timeout done");
    // Inactive counter must cross 40h to 3Fh silently; timebase period measured meanwhile
    wr(CTRL_ADDR, 8'h41);
    lows = 0;
    t1 = -1;
    t2 = -1;
    for (n = 0; n < 33000; n++) begin
      @(posedge clk_i);
      #1;
      if (rst_n !== 1'b1) lows++;
      if (tb_tick === 1'b1 && t1 >= 0 && t2 < 0) t2 = n;
      if (tb_tick === 1'b1 && t1 < 0) t1 = n;
    end
    `CHK("inactive pin lows", 0, lows)
    rd(CTRL_ADDR, 8'h00, 8'hc0);
    `CHK("timebase period", TB_PERIOD_2MS, 18'(t2 - t1))
    wr(CTRL_ADDR, 8'h80);
    `CHK("software pulse", 1'b0, rst_n)
    do_reset();
    $display("test software reset done");
    wr(CTRL_ADDR, 8'hff);
    @(posedge clk_i);
    hro_i <= 1'b1;
    pulse_halt();
    `CHK("halt pulse", 1'b0, rst_n)
    do_reset();
    @(posedge clk_i);
    hro_i <= 1'b0;
    oie_i <= 1'b1;
    pulse_halt();
    `CHK("active halt", 1'b1, ahalt_o)
    @(posedge clk_i);
    osc_i <= 1'b1;
    @(posedge clk_i);
    osc_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK("active halt wake", 1'b0, ahalt_o)
    @(posedge clk_i);
    oie_i <= 1'b0;
    wr(CTRL_ADDR, 8'h45);
    pulse_halt();
    `CHK("plain halt", 1'b1, halt_o)
    rd(CTRL_ADDR, 8'h44);
    @(posedge clk_i);
    osc_i <= 1'b1;
    @(posedge clk_i);
    osc_i <= 1'b0;
    #1;
    `CHK("plain halt osc", 1'b1, halt_o)
    @(posedge clk_i);
    ext_i <= 1'b1;
    wl_i <= 1'b1;
    @(posedge clk_i);
    ext_i <= 1'b0;
    #1;
    `CHK("plain halt wake", 1'b0, halt_o)
    $display("test halt done");
    @(posedge clk_i);
    hw_i <= 1'b1;
    do_reset();
    `CHK("hardware option", 1'b1, act_o)
    $display("test hardware option done");
    end_sim();
  end
endmodule : windowless_watchdog_timer_tb
